// *** core/memctl_pkg.sv ***
// Shared constants and types of the memory controller register interface and read path.
package memctl_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] REMAP_OFS = 8'h00;
   localparam logic [7:0] ASR_OFS = 8'h04;
   localparam logic [7:0] AAR_OFS = 8'h08;
   localparam logic [7:0] FMODE_OFS = 8'h60;
   localparam logic [7:0] LOCK_OFS = 8'h64;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int REMAP_BIT = 0;
   localparam int UND_BIT = 0;
   localparam int MIS_BIT = 1;
   localparam int SZ_LSB = 8;
   localparam int TYP_LSB = 10;
   localparam int DMA_SRC_BIT = 16;
   localparam int CPU_SRC_BIT = 17;
   localparam int DMA_SEEN_BIT = 24;
   localparam int CPU_SEEN_BIT = 25;
   localparam int FWS_LSB = 0;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] ASR_RST = 32'h0000_0000;
   localparam logic [31:0] AAR_RST = 32'h0000_0000;
   localparam logic [1:0] FWS_RST = 2'h0;
   // ----------------------------------------------------------------
   // Access encodings and memory areas
   // ----------------------------------------------------------------
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_HALF = 2'h1;
   localparam logic [1:0] SZ_WORD = 2'h2;
   localparam logic [1:0] TYP_DREAD = 2'h0;
   localparam logic [1:0] TYP_DWRITE = 2'h1;
   localparam logic [1:0] TYP_FETCH = 2'h2;
   localparam logic [3:0] TOP_INTERNAL = 4'h0;
   localparam logic [3:0] TOP_PERIPH = 4'hF;
   localparam logic [7:0] AREA_ZERO = 8'h00;
   localparam logic [7:0] AREA_FLASH = 8'h01;
   localparam logic [7:0] AREA_SRAM = 8'h02;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FLASH = 2'b01,
      ST_SRAM = 2'b10
   } acc_state_e;
endpackage : memctl_pkg

// *** core/memctl.sv ***
// Memory controller: abort status, remap, APB registers and flash read path.
`timescale 1ns/10ps
//
// Overview of operation
// - Writing one toggles remap; zero does nothing.
// - Bit 0 flags undefined-address abort.
// - Bit 1 flags misaligned-address abort.
// - Bits 9:8 record aborted access size.
// - Bits 11:10 record aborted access type.
// - Bit 16 marks DMA as last source.
// - Bit 17 marks processor as last source.
// - Bit 24 saves unreported DMA aborts, read-clear.
// - Bit 25 saves unreported processor aborts, read-clear.
// - Abort address holds full address, resets zero.
// - Abort status read-only at 0x04, resets zero.
// - Two buffers; second half prefetches next word.
// - Prefetch used for instruction fetches only.
// - Zero to three flash wait states.
// - Byte, half-word and word flash reads.
// - Flash repeats across its region, upper bits ignored.
// - One wait state: sequential fetches single-cycle.
// - Two/three states: fetches alternate long, short.
// - Write-only page buffer, any word address.
// - Lock bit per region blocks programming.
// - Misaligned data accesses abort; processor fetches exempt, DMA fetches checked.
// - Undefined areas and addresses abort.
// - Remap puts SRAM in area zero too.
module memctl #(
   parameter int FLASH_AW = 14,
   parameter int SRAM_AW = 12,
   parameter int PAGE_WORDS = 32,
   parameter int PAGES_PER_REGION = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic m_req,
   input wire logic m_master,
   input wire logic [31:0] m_addr,
   input wire logic [1:0] m_size,
   input wire logic [1:0] m_type,
   input wire logic [31:0] m_wdata,
   output logic m_done,
   output logic m_abort,
   output logic [31:0] m_rdata,
   output logic [FLASH_AW-1:0] flash_addr,
   input wire logic [31:0] flash_rdata,
   output logic sram_req,
   output logic sram_we,
   output logic [SRAM_AW-1:0] sram_addr,
   output logic [31:0] sram_wdata,
   input wire logic [31:0] sram_rdata,
   output logic remapped,
   input wire logic prog_req,
   input wire logic [FLASH_AW-$clog2(PAGE_WORDS)-1:0] prog_page,
   output logic prog_start,
   output logic prog_lock_err,
   input wire logic [$clog2(PAGE_WORDS)-1:0] pbuf_idx,
   output logic [31:0] pbuf_data
);
   import memctl_pkg::*;

   localparam int PW = $clog2(PAGE_WORDS);
   localparam int PGW = FLASH_AW - PW;
   localparam int RGS = $clog2(PAGES_PER_REGION);
   localparam int NREG = 2 ** (PGW - RGS);

   generate
      if (FLASH_AW > 20 || PW < 1 || PGW <= RGS || SRAM_AW > 18 ||
          PAGE_WORDS != 2 ** PW || PAGES_PER_REGION != 2 ** RGS) begin : g_bad
         $error("memctl: unsupported size parameters");
      end
   endgenerate

   typedef logic [FLASH_AW-1:0] faddr_t;

   typedef struct packed {
      logic remap;
      logic [1:0] flash_wait_states;
      logic [NREG-1:0] lock;
      logic und;
      logic mis;
      logic [1:0] sz;
      logic [1:0] typ;
      logic src_dma;
      logic src_cpu;
      logic seen_dma;
      logic seen_cpu;
      logic unread;
      logic [31:0] aar;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      acc_state_e st;
      logic [1:0] cnt;
      logic fetch;
      faddr_t word;
      logic done;
      logic abort;
      logic [31:0] rdata;
      faddr_t buf_tag;
      logic [31:0] buf_data;
      logic buf_ok;
      faddr_t pf_tag;
      logic [31:0] pf_data;
      logic pf_ok;
      logic pf_busy;
      logic [1:0] pf_cnt;
      faddr_t flash_addr;
      logic sram_req;
      logic sram_we;
      logic [SRAM_AW-1:0] sram_addr;
      logic [31:0] sram_wdata;
      logic [PAGE_WORDS-1:0][31:0] pbuf;
      logic [31:0] pbuf_data;
      logic prog_start;
      logic prog_err;
   } state_s;

   state_s s;
   state_s next_s;

   // ----------------------------------------------------------------
   // Address checks
   // ----------------------------------------------------------------
   function automatic logic is_undef(input logic [31:0] a);
      logic [7:0] area;
      area = a[27:20];
      if (a[31:28] == TOP_PERIPH) begin
         is_undef = 1'b0;
      end else if (a[31:28] != TOP_INTERNAL) begin
         is_undef = 1'b1;
      end else begin
         is_undef = !(area == AREA_ZERO || area == AREA_FLASH || area == AREA_SRAM);
      end
   endfunction : is_undef

   function automatic logic is_misaligned(input logic [31:0] a, input logic [1:0] sz,
                                          input logic [1:0] typ, input logic cpu);
      if (cpu && typ == TYP_FETCH) begin
         is_misaligned = 1'b0;
      end else begin
         is_misaligned = (sz == SZ_WORD && a[1:0] != 2'b00) || (sz == SZ_HALF && a[0]);
      end
   endfunction : is_misaligned

   logic take;
   logic bad_undef;
   logic bad_mis;
   logic take_abort;
   logic apb_acc;
   logic asr_read;
   logic to_sram;
   faddr_t req_word;
   faddr_t next_word;
   logic buf_hit;
   logic pf_hit;

   assign take = m_req && !s.done && s.st == ST_IDLE;
   assign bad_undef = is_undef(m_addr);
   assign bad_mis = is_misaligned(m_addr, m_size, m_type, m_master);
   assign take_abort = take && (bad_undef || bad_mis);
   assign apb_acc = psel && penable && s.pready;
   assign asr_read = apb_acc && !pwrite && paddr == ASR_OFS;
   assign to_sram = m_addr[27:20] == AREA_SRAM || (m_addr[27:20] == AREA_ZERO && s.remap);
   assign req_word = m_addr[FLASH_AW+1:2];
   assign next_word = faddr_t'(req_word + 1'b1);
   assign buf_hit = s.buf_ok && s.buf_tag == req_word;
   assign pf_hit = s.pf_ok && s.pf_tag == req_word;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
      next_s.done = 1'b0;
      next_s.abort = 1'b0;
      next_s.sram_req = 1'b0;
      next_s.prog_start = 1'b0;
      next_s.prog_err = 1'b0;
      next_s.pbuf_data = s.pbuf[pbuf_idx];

      // Register bus: data is prepared in setup, effects land in the access phase.
      if (psel && !penable) begin
         next_s.pready = 1'b1;
         next_s.prdata = 32'h0000_0000;
         case (paddr)
            ASR_OFS: begin
               next_s.prdata[UND_BIT] = s.und;
               next_s.prdata[MIS_BIT] = s.mis;
               next_s.prdata[SZ_LSB +: 2] = s.sz;
               next_s.prdata[TYP_LSB +: 2] = s.typ;
               next_s.prdata[DMA_SRC_BIT] = s.src_dma;
               next_s.prdata[CPU_SRC_BIT] = s.src_cpu;
               next_s.prdata[DMA_SEEN_BIT] = s.seen_dma;
               next_s.prdata[CPU_SEEN_BIT] = s.seen_cpu;
            end
            AAR_OFS: next_s.prdata = s.aar;
            FMODE_OFS: next_s.prdata[FWS_LSB +: 2] = s.flash_wait_states;
            LOCK_OFS: next_s.prdata[NREG-1:0] = s.lock;
            REMAP_OFS: next_s.prdata = 32'h0000_0000;
            default: next_s.pslverr = 1'b1;
         endcase
      end
      if (apb_acc && pwrite) begin
         case (paddr)
            REMAP_OFS: if (pwdata[REMAP_BIT]) next_s.remap = !s.remap;
            FMODE_OFS: next_s.flash_wait_states = pwdata[FWS_LSB +: 2];
            LOCK_OFS: next_s.lock = pwdata[NREG-1:0];
            default: next_s.remap = s.remap;
         endcase
      end
      if (asr_read) begin
         next_s.seen_dma = 1'b0;
         next_s.seen_cpu = 1'b0;
         next_s.unread = 1'b0;
      end

      // A region lock refuses the programming start.
      if (prog_req) begin
         if (s.lock[prog_page[PGW-1:RGS]]) begin
            next_s.prog_err = 1'b1;
         end else begin
            next_s.prog_start = 1'b1;
         end
      end

      // Prefetch engine shares the flash port with demand reads.
      if (s.pf_busy) begin
         if (s.pf_cnt == 2'h0) begin
            next_s.pf_busy = 1'b0;
            next_s.pf_ok = 1'b1;
            next_s.pf_data = flash_rdata;
         end else begin
            next_s.pf_cnt = s.pf_cnt - 2'h1;
         end
      end

      case (s.st)
         ST_IDLE: begin
            if (take_abort) begin
               // Set wins over a same-cycle status read.
               next_s.seen_dma = (asr_read ? 1'b0 : s.seen_dma) | (s.unread & s.src_dma);
               next_s.seen_cpu = (asr_read ? 1'b0 : s.seen_cpu) | (s.unread & s.src_cpu);
               next_s.unread = 1'b1;
               next_s.und = bad_undef;
               next_s.mis = bad_mis;
               next_s.sz = m_size;
               next_s.typ = m_type;
               next_s.src_dma = !m_master;
               next_s.src_cpu = m_master;
               next_s.aar = m_addr;
               next_s.done = 1'b1;
               next_s.abort = 1'b1;
            end else if (take && m_addr[31:28] == TOP_PERIPH) begin
               next_s.done = 1'b1;
               next_s.rdata = 32'h0000_0000;
            end else if (take && to_sram) begin
               next_s.sram_req = 1'b1;
               next_s.sram_we = m_type == TYP_DWRITE;
               next_s.sram_addr = m_addr[SRAM_AW+1:2];
               next_s.sram_wdata = m_wdata;
               next_s.st = ST_SRAM;
            end else if (take && m_type == TYP_DWRITE) begin
               // Narrow writes are not stored; they would corrupt the latched word.
               if (m_size == SZ_WORD) begin
                  next_s.pbuf[req_word[PW-1:0]] = m_wdata;
               end
               next_s.done = 1'b1;
            end else if (take && m_type == TYP_FETCH && (buf_hit || pf_hit)) begin
               next_s.done = 1'b1;
               next_s.rdata = buf_hit ? s.buf_data : s.pf_data;
               if (!buf_hit) begin
                  next_s.buf_tag = s.pf_tag;
                  next_s.buf_data = s.pf_data;
                  next_s.buf_ok = 1'b1;
                  next_s.pf_ok = 1'b0;
               end
               if (m_addr[1] && !s.pf_busy && !(s.pf_ok && s.pf_tag == next_word)) begin
                  next_s.pf_busy = 1'b1;
                  next_s.pf_ok = 1'b0;
                  next_s.pf_tag = next_word;
                  next_s.pf_cnt = s.flash_wait_states;
                  next_s.flash_addr = next_word;
               end
            end else if (take && !s.pf_busy) begin
               next_s.flash_addr = req_word;
               next_s.word = req_word;
               next_s.fetch = m_type == TYP_FETCH;
               next_s.cnt = s.flash_wait_states;
               next_s.st = ST_FLASH;
            end
         end
         ST_FLASH: begin
            if (s.cnt == 2'h0) begin
               next_s.done = 1'b1;
               next_s.rdata = flash_rdata;
               next_s.st = ST_IDLE;
               if (s.fetch) begin
                  next_s.buf_tag = s.word;
                  next_s.buf_data = flash_rdata;
                  next_s.buf_ok = 1'b1;
               end
            end else begin
               next_s.cnt = s.cnt - 2'h1;
            end
         end
         ST_SRAM: begin
            next_s.done = 1'b1;
            next_s.rdata = sram_rdata;
            next_s.st = ST_IDLE;
         end
         default: next_s.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.flash_wait_states <= FWS_RST;
         s.aar <= AAR_RST;
         s.st <= ST_IDLE;
         {s.seen_cpu, s.seen_dma, s.src_cpu, s.src_dma} <= ASR_RST[3:0];
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign m_done = s.done;
   assign m_abort = s.abort;
   assign m_rdata = s.rdata;
   assign flash_addr = s.flash_addr;
   assign sram_req = s.sram_req;
   assign sram_we = s.sram_we;
   assign sram_addr = s.sram_addr;
   assign sram_wdata = s.sram_wdata;
   assign remapped = s.remap;
   assign prog_start = s.prog_start;
   assign prog_lock_err = s.prog_err;
   assign pbuf_data = s.pbuf_data;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   logic demand_issue;
   assign demand_issue = s.st == ST_IDLE && next_s.st == ST_FLASH;

   sequence s_remap_write;
      apb_acc && pwrite && paddr == REMAP_OFS;
   endsequence

   property p_remap_toggle;
      s_remap_write and pwdata[REMAP_BIT] |=> remapped != $past(remapped);
   endproperty
   a_remap_toggle: assert property (p_remap_toggle) else $error("remap did not toggle");

   property p_remap_zero;
      s_remap_write and !pwdata[REMAP_BIT] |=> $stable(remapped);
   endproperty
   a_remap_zero: assert property (p_remap_zero) else $error("remap moved on zero write");

   property p_abort_record;
      take_abort |=> s.und == $past(bad_undef) && s.mis == $past(bad_mis) &&
                     s.aar == $past(m_addr) && s.sz == $past(m_size) && m_abort && m_done;
   endproperty
   a_abort_record: assert property (p_abort_record) else $error("abort fields wrong");

   property p_source;
      take_abort |=> s.src_cpu == $past(m_master) && s.src_dma == !s.src_cpu;
   endproperty
   a_source: assert property (p_source) else $error("abort source wrong");

   property p_seen_clear;
      asr_read && !take_abort |=> !s.seen_dma && !s.seen_cpu;
   endproperty
   a_seen_clear: assert property (p_seen_clear) else $error("saved sources not cleared");

   property p_asr_ro;
      apb_acc && pwrite && paddr == ASR_OFS && !take_abort |=> $stable(s.sz) && $stable(s.und);
   endproperty
   a_asr_ro: assert property (p_asr_ro) else $error("status changed by write");

   sequence s_flash_wait0;
      demand_issue && s.flash_wait_states == 2'h0 ##1 s.st == ST_FLASH;
   endsequence

   property p_fws0;
      s_flash_wait0 |=> m_done;
   endproperty
   a_fws0: assert property (p_fws0) else $error("zero wait read late");

   property p_fws3;
      demand_issue && s.flash_wait_states == 2'h3 |-> !m_done [*5] ##1 m_done;
   endproperty
   a_fws3: assert property (p_fws3) else $error("three wait read timing");

   property p_hit;
      take && m_type == TYP_FETCH && buf_hit && !take_abort && !to_sram &&
         m_addr[31:28] != TOP_PERIPH |=>
         m_done && m_rdata == $past(s.buf_data);
   endproperty
   a_hit: assert property (p_hit) else $error("buffer hit not single cycle");

   property p_data_nobuf;
      s.st == ST_FLASH && !s.fetch |=> $stable(s.buf_tag);
   endproperty
   a_data_nobuf: assert property (p_data_nobuf) else $error("data read filled buffer");

   property p_lock;
      prog_req && s.lock[prog_page[PGW-1:RGS]] |=> prog_lock_err && !prog_start;
   endproperty
   a_lock: assert property (p_lock) else $error("locked region started");

endmodule : memctl

// *** bench/mem_array_model.sv ***
// Flash array and SRAM model on the far side of the memory controller.
`timescale 1ns/10ps
module mem_array_model #(
   parameter int FLASH_AW = 14,
   parameter int SRAM_AW = 12
) (
   input wire logic clk,
   input wire logic [FLASH_AW-1:0] flash_addr,
   output logic [31:0] flash_rdata,
   input wire logic sram_req,
   input wire logic sram_we,
   input wire logic [SRAM_AW-1:0] sram_addr,
   input wire logic [31:0] sram_wdata,
   output logic [31:0] sram_rdata
);
   logic [31:0] mem [0:(1<<SRAM_AW)-1];
   // Each flash word carries its own word address, so wrap-around and lane faults show.
   assign flash_rdata = 32'h5A00_0000 | 32'(flash_addr);
   logic [31:0] idle_word;
   initial idle_word = 32'h0000_0000;
   always @(posedge clk) begin
      if (sram_req && sram_we) begin
         mem[sram_addr] <= sram_wdata;
      end
      idle_word <= ~idle_word;
   end
   // The controller samples read data at the edge that ends its request cycle, so the word
   // is shown at once; outside a read the bus keeps changing to expose a mistimed sample.
   assign sram_rdata = (sram_req && !sram_we) ? mem[sram_addr] : idle_word;
endmodule : mem_array_model

// *** bench/memctl_tb.sv ***
// Self-checking testbench of the memory controller.
`timescale 1ns/10ps
module memctl_tb;
   import memctl_pkg::*;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, m_req, m_master, m_done, m_abort;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, m_addr, m_wdata, m_rdata, flash_rdata, sram_wdata, sram_rdata;
   logic [31:0] pbuf_data, q;
   logic [1:0] m_size, m_type;
   logic [13:0] flash_addr;
   logic [11:0] sram_addr;
   logic sram_req, sram_we, remapped, prog_req, prog_start, prog_lock_err, ab, er;
   logic [8:0] prog_page;
   logic [4:0] pbuf_idx;
   int err_count, tests_run, lat;
   memctl u_memctl (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .m_req(m_req), .m_master(m_master), .m_addr(m_addr), .m_size(m_size), .m_type(m_type),
      .m_wdata(m_wdata), .m_done(m_done), .m_abort(m_abort), .m_rdata(m_rdata),
      .flash_addr(flash_addr), .flash_rdata(flash_rdata), .sram_req(sram_req), .sram_we(sram_we),
      .sram_addr(sram_addr), .sram_wdata(sram_wdata), .sram_rdata(sram_rdata),
      .remapped(remapped), .prog_req(prog_req), .prog_page(prog_page), .prog_start(prog_start),
      .prog_lock_err(prog_lock_err), .pbuf_idx(pbuf_idx), .pbuf_data(pbuf_data));
   mem_array_model u_mem_array_model (.clk(clk), .flash_addr(flash_addr),
      .flash_rdata(flash_rdata), .sram_req(sram_req), .sram_we(sram_we),
      .sram_addr(sram_addr), .sram_wdata(sram_wdata), .sram_rdata(sram_rdata));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (n > 20) begin
            check("apb pready timeout", 32'h0000_0001, 32'h0000_0000);
            tally_and_finish();
         end
      end while (pready !== 1'b1);
      q = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Latency counts cycles from the edge that takes the request to the first edge that samples done high.
   task automatic bus(input logic mst, input logic [31:0] a, input logic [1:0] sz,
         input logic [1:0] ty, input logic [31:0] d);
      @(posedge clk);
      m_req <= 1'b1;
      m_master <= mst;
      m_addr <= a;
      m_size <= sz;
      m_type <= ty;
      m_wdata <= d;
      lat = -1;
      do begin
         @(posedge clk);
         lat++;
         if (lat > 40) begin
            check("bus done timeout", 32'h0000_0001, 32'h0000_0000);
            tally_and_finish();
         end
      end while (m_done !== 1'b1);
      q = m_rdata;
      ab = m_abort;
      m_req <= 1'b0;
   endtask : bus
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs;
      apb(1'b0, ASR_OFS, 32'h0000_0000);
      check("status reset", ASR_RST, q);
      apb(1'b0, AAR_OFS, 32'h0000_0000);
      check("abort address reset", AAR_RST, q);
      apb(1'b1, ASR_OFS, 32'hFFFF_FFFF);
      apb(1'b0, ASR_OFS, 32'h0000_0000);
      check("status after write", 32'h0000_0000, q);
      apb(1'b0, 8'h20, 32'h0000_0000);
      check("unmapped error", 32'h0000_0001, 32'(er));
      $display("test regs done");
   endtask : t_regs
   task automatic t_remap;
      bus(1'b0, 32'h0020_0010, SZ_WORD, TYP_DWRITE, 32'h1234_ABCD);
      apb(1'b1, REMAP_OFS, 32'h0000_0000);
      @(posedge clk);
      check("remap after zero", 32'h0000_0000, 32'(remapped));
      apb(1'b1, REMAP_OFS, 32'h0000_0001);
      @(posedge clk);
      check("remap after one", 32'h0000_0001, 32'(remapped));
      bus(1'b0, 32'h0000_0010, SZ_WORD, TYP_DREAD, 32'h0000_0000);
      check("area zero sram", 32'h1234_ABCD, q);
      apb(1'b1, REMAP_OFS, 32'h0000_0001);
      @(posedge clk);
      check("remap toggled back", 32'h0000_0000, 32'(remapped));
      bus(1'b0, 32'h0000_0010, SZ_WORD, TYP_DREAD, 32'h0000_0000);
      check("area zero flash", 32'h5A00_0004, q);
      $display("test remap done");
   endtask : t_remap
   task automatic t_abort;
      bus(1'b0, 32'h3000_0000, SZ_WORD, TYP_DREAD, 32'h0000_0000);
      check("undefined area abort", 32'h0000_0001, 32'(ab));
      bus(1'b0, 32'h0010_0003, SZ_HALF, TYP_DWRITE, 32'h0000_0000);
      check("misaligned abort", 32'h0000_0001, 32'(ab));
      apb(1'b0, ASR_OFS, 32'h0000_0000);
      check("dma status", 32'h0101_0502, q);
      apb(1'b0, AAR_OFS, 32'h0000_0000);
      check("dma abort address", 32'h0010_0003, q);
      apb(1'b0, ASR_OFS, 32'h0000_0000);
      check("dma saved cleared", 32'h0001_0502, q);
      bus(1'b1, 32'h0010_0002, SZ_WORD, TYP_FETCH, 32'h0000_0000);
      check("fetch not checked", 32'h0000_0000, 32'(ab));
      bus(1'b1, 32'h5000_0001, SZ_BYTE, TYP_DREAD, 32'h0000_0000);
      bus(1'b1, 32'h2000_0000, SZ_WORD, TYP_FETCH, 32'h0000_0000);
      check("fetch abort", 32'h0000_0001, 32'(ab));
      apb(1'b0, ASR_OFS, 32'h0000_0000);
      check("cpu status", 32'h0202_0A01, q);
      apb(1'b0, ASR_OFS, 32'h0000_0000);
      check("cpu saved cleared", 32'h0002_0A01, q);
      apb(1'b0, AAR_OFS, 32'h0000_0000);
      check("cpu abort address", 32'h2000_0000, q);
      $display("test abort done");
   endtask : t_abort
   task automatic t_flash;
      for (int w = 0; w < 4; w++) begin
         apb(1'b1, FMODE_OFS, 32'(w));
         bus(1'b0, 32'h0010_0008, SZ_WORD, TYP_DREAD, 32'h0000_0000);
         check("word read data", 32'h5A00_0002, q);
         check("word read cycles", 32'(w + 2), 32'(lat));
         bus(1'b0, 32'h0011_000A, SZ_HALF, TYP_DREAD, 32'h0000_0000);
         check("wrapped half data", 32'h5A00_0002, q);
         check("data read no prefetch", 32'(w + 2), 32'(lat));
         bus(1'b0, 32'h0010_0005, SZ_BYTE, TYP_DREAD, 32'h0000_0000);
         check("byte read data", 32'h5A00_0001, q);
      end
      for (int w = 1; w < 4; w += 2) begin
         apb(1'b1, FMODE_OFS, 32'(w));
         bus(1'b1, 32'h0010_0040 + 32'(w * 64), SZ_HALF, TYP_FETCH, 32'h0000_0000);
         check("first fetch cycles", 32'(w + 2), 32'(lat));
         bus(1'b1, 32'h0010_0042 + 32'(w * 64), SZ_HALF, TYP_FETCH, 32'h0000_0000);
         check("second fetch cycles", 32'h0000_0001, 32'(lat));
         check("second fetch data", 32'h5A00_0010 + 32'(w * 16), q);
         bus(1'b1, 32'h0010_0044 + 32'(w * 64), SZ_HALF, TYP_FETCH, 32'h0000_0000);
         check("prefetched word", 32'h5A00_0011 + 32'(w * 16), q);
      end
      $display("test flash done");
   endtask : t_flash
   task automatic t_prog;
      bus(1'b0, 32'h0013_0008, SZ_WORD, TYP_DWRITE, 32'hC0DE_1234);
      @(posedge clk);
      pbuf_idx <= 5'h02;
      @(posedge clk);
      @(negedge clk);
      check("page buffer word", 32'hC0DE_1234, pbuf_data);
      apb(1'b1, LOCK_OFS, 32'h0000_0001);
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         prog_req <= 1'b1;
         prog_page <= 9'(p * 32);
         @(posedge clk);
         prog_req <= 1'b0;
         @(negedge clk);
         check("lock error", 32'(p == 0), 32'(prog_lock_err));
         check("program start", 32'(p == 1), 32'(prog_start));
      end
      $display("test prog done");
   endtask : t_prog
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      {rst_n, psel, penable, pwrite, m_req, m_master, prog_req} = '0;
      {paddr, pwdata, m_addr, m_wdata, m_size, m_type, prog_page, pbuf_idx} = '0;
      err_count = 0;
      tests_run = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_remap();
      t_abort();
      t_flash();
      t_prog();
      tally_and_finish();
   end
endmodule : memctl_tb
